/* File: cpuse_alu.sv */
// cpuse_alu: result and zero flag of the file invert and file minus one commands
`timescale 1ns/1ps
`default_nettype none
module cpuse_alu (
    // command
    input  wire cpuse_pkg::cpuse_op_e op,
    // operand from the addressed file register
    input  wire logic [7:0]           fval,
    // result
    output logic [7:0]                result,
    output logic                      zero
);
    // pure combinational datapath, no state
    always_comb begin
        case (op)
            cpuse_pkg::OP_FINV: begin
                result = ~fval;
            end
            cpuse_pkg::OP_FDEC: begin
                result = fval - cpuse_pkg::BYTE_ONE;
            end
            default: begin
                result = cpuse_pkg::BYTE_ZERO;  // clear commands give zero
            end
        endcase
        zero = (result == cpuse_pkg::BYTE_ZERO);
    end
endmodule
`default_nettype wire

/* File: cpuse_pkg.sv */
// cpuse_pkg: constants, commands and state types of the instruction subset unit
package cpuse_pkg;
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register byte offsets
    localparam logic [7:0] OFF_CMD   = 8'h00;
    localparam logic [7:0] OFF_PC    = 8'h04;
    localparam logic [7:0] OFF_PAGE  = 8'h08;
    localparam logic [7:0] OFF_ACCUM = 8'h0c;
    localparam logic [7:0] OFF_STAT  = 8'h10;
    localparam logic [7:0] OFF_STACK = 8'h14;
    localparam logic [7:0] OFF_WDOG  = 8'h18;
    localparam logic [7:0] OFF_FADDR = 8'h1c;
    localparam logic [7:0] OFF_FDATA = 8'h20;
    // command word fields
    localparam int CMD_OP_LSB = 12;
    localparam int CMD_D_BIT  = 7;
    localparam int K_W        = 11;
    localparam int F_W        = 7;
    // status register bits
    localparam int ST_ZERO = 0;
    localparam int ST_PD   = 1;
    localparam int ST_TO   = 2;
    localparam int ST_BUSY = 3;
    // widths and depths
    localparam int PC_W     = 13;
    localparam int PAGE_W   = 5;
    localparam int PAGE_LSB = 3;
    localparam int STK_D    = 8;
    localparam int SP_W     = 3;
    localparam int NFILES   = 128;
    // reset and constant values
    localparam logic [7:0]      BYTE_ZERO = 8'h00;
    localparam logic [7:0]      BYTE_ONE  = 8'h01;
    localparam logic [PC_W-1:0] PC_ONE    = 13'h0001;
    localparam logic [SP_W-1:0] SP_ONE    = 3'h1;
    // command opcodes
    typedef enum logic [2:0] {
        OP_NOP   = 3'b000,
        OP_CALL  = 3'b001,
        OP_KICK  = 3'b010,
        OP_FZERO = 3'b011,
        OP_AZERO = 3'b100,
        OP_FINV  = 3'b101,
        OP_FDEC  = 3'b110
    } cpuse_op_e;
    // one bus request as seen by the slave
    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [3:0]        be;
    } cpuse_req_s;
    // complete state of the unit
    typedef struct packed {
        logic                          waitreq;
        logic [DATA_W-1:0]             rdata;
        logic                          busy;
        logic [PC_W-1:0]               target;
        logic [PC_W-1:0]               pc;
        logic [PAGE_W-1:0]             page_latch;
        logic [7:0]                    accum;
        logic                          zero;
        logic                          timeout_flag;
        logic                          powerdown_flag;
        logic [SP_W-1:0]               sp;
        logic [STK_D-1:0][PC_W-1:0]    stack;
        logic [7:0]                    wdog;
        logic [7:0]                    presc;
        logic [F_W-1:0]                faddr;
        logic [NFILES-1:0][7:0]        files;
    } cpuse_state_s;
endpackage

/* File: cpuse_top.sv */
// cpuse_top: instruction subset unit behind an avalon-mm slave
// overview
// software plays the part of the fetch stage: each write of the
// command word is one instruction, and the unit executes it at the
// edge where the bus transfer completes. there is no program memory
// here; the program counter only tracks where a real core would be.
//
// register map, byte offsets, all 32-bit words
//   00 command word, write only
//   04 program counter, read only, 13 bits
//   08 page latch, read/write, 5 bits
//   0c working register, read only, 8 bits
//   10 status, read only
//      bit 0 zero flag
//      bit 1 power-down flag
//      bit 2 timeout flag
//      bit 3 busy, high in a call's second cycle
//   14 return stack top, read only, 13 bits
//   18 watchdog, read only
//      bits 7..0 counter, bits 15..8 prescaler
//   1c file address, read/write, 7 bits
//   20 file data, read/write, 8 bits, at file address
// unmapped offsets read as zero; writes to them are acked and lost.
// only exact word offsets decode, so the low address bits must be 0.
//
// command word layout
//   bits 14..12 opcode
//     0 no operation
//     1 call
//     2 watchdog kick
//     3 file zero
//     4 accum zero
//     5 file invert
//     6 file minus one
//     7 no operation, reserved
//   bits 10..0 call target, k
//   bits 6..0 file index for the file commands
//   bit 7 destination: 0 working register, 1 file
// byte enables are ignored on the command word: a command is always
// taken whole, since half a command has no meaning.
//
// bus timing
//   every transfer sees one wait cycle: the request is seen at one
//   edge, waitrequest falls after it, and the transfer completes at
//   the next edge. read data is loaded together with the fall of
//   waitrequest, so it stands at the completing edge.
//   a request that arrives during a call's second cycle waits one
//   cycle more; this keeps a command from racing the jump.
//   waitrequest is high in reset and while idle, so a master that
//   starts early simply waits.
//
// call timing
//   first cycle: the return address is pushed and the stack pointer
//   moves; the program counter still holds the call's own address.
//   second cycle: the program counter takes the saved target and the
//   busy bit drops. no status flag moves in either cycle.
//
// return stack
//   eight entries, a plain ring: a ninth push overwrites the oldest
//   entry with no warning, as in the core this models. software that
//   nests deeper than eight loses return addresses silently.
//   there is no return command in this subset, so nothing pops.
//
// watchdog
//   the prescaler counts every clock; the counter steps when the
//   prescaler wraps. a counter wrap clears the timeout flag. a kick
//   clears both counts and sets both flags; if a wrap and a kick fall
//   in one cycle the kick wins, because software acted last.
//   a full wrap takes 65536 clocks, 655 us at 100 mhz.
//   nothing here resets the core on a timeout: the flag is the only
//   trace, and whoever owns the system reset must watch it.
//
// power-down flag
//   there is no sleep logic in this unit, so the flag is only ever
//   set, by reset or by a kick. it is kept so software sees the same
//   status layout as on the full core.
//
// file registers
//   128 bytes of flip-flops. this is costly in area, but a memory
//   macro would add a read cycle and break the one-wait timing of
//   the read-modify-write commands.
//
// zero flag
//   set by the two clear commands, computed from the result by the
//   invert and minus one commands, untouched by everything else.
//
// limits
//   no carry or digit carry flag is kept, so the minus one command
//   cannot be chained for wider arithmetic.
//   the state is one wide register; all updates go through st_d.
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cpuse_top (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // core state seen from outside
    output logic      [12:0] program_counter,
    output logic      [12:0] stack_top,
    output logic             timeout_flag,
    output logic             powerdown_flag
);
    cpuse_pkg::cpuse_req_s   req;      // bundled bus request
    cpuse_pkg::cpuse_state_s st_q;     // registered state
    cpuse_pkg::cpuse_state_s st_d;     // next state
    cpuse_pkg::cpuse_op_e    op;       // decoded opcode of a command write
    logic [7:0]              fsel;     // addressed file for a command
    logic [7:0]              alu_res;  // invert or minus one result
    logic                    alu_zero; // zero flag of that result
    logic [31:0]             wmerged;  // write data after byte enables
    logic [31:0]             rsel;     // read mux value
    logic [31:0]             cur;      // current value of the written word
    logic                    ack;      // request completes at this edge
    logic [12:0]             ret_addr; // return address for a call
    logic [6:0]              fidx;     // file index of a command
    logic [2:0]              top_idx;  // index of the stack top slot

    // bundle the published bus signals
    assign req = '{read:  avs_read,
                   write: avs_write,
                   addr:  avs_address,
                   wdata: avs_writedata,
                   be:    avs_byteenable};

    // command word decode
    assign op   = cpuse_pkg::cpuse_op_e'(req.wdata[cpuse_pkg::CMD_OP_LSB +: 3]);
    assign fidx = req.wdata[cpuse_pkg::F_W-1:0];
    assign fsel = st_q.files[fidx];

    // the request ends at the edge where waitrequest is seen low
    assign ack = (req.read || req.write) && !st_q.waitreq;

    // return address is the following instruction
    assign ret_addr = st_q.pc + cpuse_pkg::PC_ONE;

    // slot that holds the most recent push
    assign top_idx = st_q.sp - cpuse_pkg::SP_ONE;

    // shared datapath for the two read-modify-write commands
    cpuse_alu u_alu (
        .op     (op),
        .fval   (fsel),
        .result (alu_res),
        .zero   (alu_zero)
    );

    // current value of the addressed register, for byte-enable merging
    always_comb begin
        case (req.addr)
            cpuse_pkg::OFF_PAGE: begin
                cur = {27'h0000000, st_q.page_latch};
            end
            cpuse_pkg::OFF_FADDR: begin
                cur = {25'h0000000, st_q.faddr};
            end
            cpuse_pkg::OFF_FDATA: begin
                cur = {24'h000000, st_q.files[st_q.faddr]};
            end
            default: begin
                cur = 32'h00000000;  // command word has no stored value
            end
        endcase
    end

    // merge write data under byte enables
    always_comb begin
        wmerged = cur;
        for (int i = 0; i < 4; i++) begin
            if (req.be[i]) begin
                wmerged[i*8 +: 8] = req.wdata[i*8 +: 8];
            end
        end
    end

    // read mux; unmapped offsets read as zero
    always_comb begin
        case (req.addr)
            cpuse_pkg::OFF_PC: begin
                rsel = {19'h00000, st_q.pc};
            end
            cpuse_pkg::OFF_PAGE: begin
                rsel = {27'h0000000, st_q.page_latch};
            end
            cpuse_pkg::OFF_ACCUM: begin
                rsel = {24'h000000, st_q.accum};
            end
            cpuse_pkg::OFF_STAT: begin
                rsel = 32'h00000000;
                rsel[cpuse_pkg::ST_ZERO] = st_q.zero;
                rsel[cpuse_pkg::ST_PD]   = st_q.powerdown_flag;
                rsel[cpuse_pkg::ST_TO]   = st_q.timeout_flag;
                rsel[cpuse_pkg::ST_BUSY] = st_q.busy;
            end
            cpuse_pkg::OFF_STACK: begin
                rsel = {19'h00000, st_q.stack[top_idx]};
            end
            cpuse_pkg::OFF_WDOG: begin
                rsel = {16'h0000, st_q.presc, st_q.wdog};
            end
            cpuse_pkg::OFF_FADDR: begin
                rsel = {25'h0000000, st_q.faddr};
            end
            cpuse_pkg::OFF_FDATA: begin
                rsel = {24'h000000, st_q.files[st_q.faddr]};
            end
            default: begin
                rsel = 32'h00000000;
            end
        endcase
    end

    // next-state logic: bus handshake, watchdog, command execution
    always_comb begin
        st_d = st_q;

        // watchdog: prescaler counts every clock, counter on its wrap
        st_d.presc = st_q.presc + cpuse_pkg::BYTE_ONE;
        if (st_q.presc == 8'hff) begin
            st_d.wdog = st_q.wdog + cpuse_pkg::BYTE_ONE;
            // a counter overflow marks a watchdog timeout
            if (st_q.wdog == 8'hff) begin
                st_d.timeout_flag = 1'b0;
            end
        end

        // second cycle of a call: jump to the saved target
        if (st_q.busy) begin
            st_d.pc   = st_q.target;
            st_d.busy = 1'b0;
        end

        // handshake: one wait cycle, held longer while a call finishes
        if (ack) begin
            st_d.waitreq = 1'b1;  // release, ready for the next request
        end else if ((req.read || req.write) && !st_q.busy) begin
            st_d.waitreq = 1'b0;  // answer at the next edge
            st_d.rdata   = req.read ? rsel : st_q.rdata;
        end else begin
            st_d.waitreq = 1'b1;
        end

        // writes take effect only at the acknowledging edge
        if (ack && req.write) begin
            case (req.addr)
                cpuse_pkg::OFF_CMD: begin
                    // every command but a call advances one word
                    st_d.pc = ret_addr;
                    case (op)
                        cpuse_pkg::OP_CALL: begin
                            // push first, jump on the following cycle
                            st_d.stack[st_q.sp] = ret_addr;
                            st_d.sp = st_q.sp + cpuse_pkg::SP_ONE;
                            st_d.pc = st_q.pc;
                            st_d.target = {
                                st_q.page_latch[cpuse_pkg::PAGE_LSB +: 2],
                                req.wdata[cpuse_pkg::K_W-1:0]};
                            // flags are left alone
                            st_d.busy = 1'b1;
                        end
                        cpuse_pkg::OP_KICK: begin
                            // the kick wins over a same-cycle timeout
                            st_d.wdog           = cpuse_pkg::BYTE_ZERO;
                            st_d.presc          = cpuse_pkg::BYTE_ZERO;
                            st_d.timeout_flag   = 1'b1;
                            st_d.powerdown_flag = 1'b1;
                        end
                        cpuse_pkg::OP_FZERO: begin
                            st_d.files[fidx] = cpuse_pkg::BYTE_ZERO;
                            st_d.zero = 1'b1;
                        end
                        cpuse_pkg::OP_AZERO: begin
                            st_d.accum = cpuse_pkg::BYTE_ZERO;
                            st_d.zero  = 1'b1;
                        end
                        cpuse_pkg::OP_FINV, cpuse_pkg::OP_FDEC: begin
                            // destination select picks file or accum
                            if (req.wdata[cpuse_pkg::CMD_D_BIT]) begin
                                st_d.files[fidx] = alu_res;
                            end else begin
                                st_d.accum = alu_res;
                            end
                            st_d.zero = alu_zero;
                        end
                        default: begin
                            // no operation, program counter only
                        end
                    endcase
                end
                cpuse_pkg::OFF_PAGE: begin
                    st_d.page_latch = wmerged[cpuse_pkg::PAGE_W-1:0];
                end
                cpuse_pkg::OFF_FADDR: begin
                    st_d.faddr = wmerged[cpuse_pkg::F_W-1:0];
                end
                cpuse_pkg::OFF_FDATA: begin
                    st_d.files[st_q.faddr] = wmerged[7:0];
                end
                default: begin
                    // read-only or unmapped: write is accepted and dropped
                end
            endcase
        end
    end

    // state register; reset holds the bus stalled and the timeout and power-down flags set
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_q                <= '0;
            st_q.waitreq        <= 1'b1;
            st_q.timeout_flag   <= 1'b1;
            st_q.powerdown_flag <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state flip-flops
    assign avs_readdata    = st_q.rdata;
    assign avs_waitrequest = st_q.waitreq;
    assign program_counter = st_q.pc;
    assign stack_top       = st_q.stack[top_idx];
    assign timeout_flag    = st_q.timeout_flag;
    assign powerdown_flag  = st_q.powerdown_flag;
endmodule
`default_nettype wire

/* File: cpuse_top_chk.sv */
// cpuse_chk: port-level assertions for the instruction subset unit
`timescale 1ns/1ps
`default_nettype none
module cpuse_chk (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_b,
    // avalon-mm slave
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // core state
    input wire logic [12:0] program_counter,
    input wire logic [12:0] stack_top,
    input wire logic        timeout_flag,
    input wire logic        powerdown_flag
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic       wr_ok;  // write completes at this edge
    logic       rd_ok;  // read completes at this edge
    logic [2:0] wop;    // op field of the write data
    logic [4:0] page_q; // shadow of the page latch
    logic [2:0] op_q;   // op of the last command
    logic [7:0] kcnt_q; // age of the last kick, ff once stale
    assign wr_ok = avs_write && !avs_waitrequest;
    assign rd_ok = avs_read && !avs_waitrequest;
    assign wop = avs_writedata[14:12];
    // shadow state; the kick age saturates so that old kicks drop out
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            page_q <= 5'h00;
            op_q <= 3'h0;
            kcnt_q <= 8'hff;
        end else begin
            if (wr_ok && avs_address == cpuse_pkg::OFF_PAGE && avs_byteenable[0])
                page_q <= avs_writedata[4:0];
            if (wr_ok && avs_address == cpuse_pkg::OFF_CMD)
                op_q <= wop;
            if (wr_ok && avs_address == cpuse_pkg::OFF_CMD && wop == cpuse_pkg::OP_KICK)
                kcnt_q <= 8'h00;
            else if (kcnt_q != 8'hff)
                kcnt_q <= kcnt_q + 8'h01;
        end
    end
    sequence s_call;
        wr_ok && avs_address == cpuse_pkg::OFF_CMD && wop == cpuse_pkg::OP_CALL;
    endsequence
    sequence s_kick;
        wr_ok && avs_address == cpuse_pkg::OFF_CMD && wop == cpuse_pkg::OP_KICK;
    endsequence
    property p_push;
        s_call |=> stack_top == $past(program_counter) + 13'h0001;
    endproperty
    a_push: assert property (p_push) else $error("return address wrong");
    property p_target;
        s_call |=> ##1 program_counter == {page_q[4:3], $past(avs_writedata[10:0], 2)};
    endproperty
    a_target: assert property (p_target) else $error("call target wrong");
    property p_two;
        s_call |=> avs_waitrequest [*2];
    endproperty
    a_two: assert property (p_two) else $error("call not two cycles");
    property p_kick;
        s_kick |=> timeout_flag && powerdown_flag;
    endproperty
    a_kick: assert property (p_kick) else $error("kick flags not set");
    property p_pd;
        !$fell(powerdown_flag);
    endproperty
    a_pd: assert property (p_pd) else $error("powerdown flag cleared");
    property p_presc;
        rd_ok && avs_address == cpuse_pkg::OFF_WDOG && kcnt_q < 8'hc8
            |-> avs_readdata[15:8] <= kcnt_q && avs_readdata[7:0] == 8'h00;
    endproperty
    a_presc: assert property (p_presc) else $error("watchdog not cleared");
    property p_zset;
        rd_ok && avs_address == cpuse_pkg::OFF_STAT
            && (op_q == cpuse_pkg::OP_FZERO || op_q == cpuse_pkg::OP_AZERO)
            |-> avs_readdata[cpuse_pkg::ST_ZERO];
    endproperty
    a_zset: assert property (p_zset) else $error("zero flag not set");
    property p_azero;
        rd_ok && avs_address == cpuse_pkg::OFF_ACCUM && op_q == cpuse_pkg::OP_AZERO
            |-> avs_readdata[7:0] == 8'h00;
    endproperty
    a_azero: assert property (p_azero) else $error("accum not cleared");
endmodule
bind cpuse_top cpuse_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .program_counter(program_counter),
    .stack_top(stack_top), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));
`default_nettype wire

/* File: tb_cpu_instruction_subset_exec.sv */
// tb_cpu_instruction_subset_exec: bus-level tests of the instruction subset unit
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_instruction_subset_exec;
    logic        clk_sys = 1'b0;         // 100 MHz
    logic        rst_b = 1'b0;           // async, active low
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;  // full words only
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [12:0] program_counter;
    logic [12:0] stack_top;
    logic        timeout_flag;
    logic        powerdown_flag;
    int          n_mismatch = 0;
    int          checked = 0;
    logic [12:0] epc = 13'h0;            // expected program counter
    logic [4:0]  pg = 5'h0;              // expected page latch
    logic [31:0] rv;                     // last read data
    cpuse_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .program_counter(program_counter),
        .stack_top(stack_top), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));
    // free-running clock
    always #5 clk_sys = ~clk_sys;
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one avalon transfer; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rv = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // issue a command and follow the program counter; the wait covers a call's second cycle
    task automatic cmd(input logic [2:0] op, input logic [10:0] arg);
        bus(1'b1, cpuse_pkg::OFF_CMD, {17'h0, op, 1'b0, arg});
        repeat (2) @(posedge clk_sys);
        if (op == cpuse_pkg::OP_CALL) begin
            chk(stack_top, epc + 13'h1);
            epc = {pg[4:3], arg};
        end else
            epc = epc + 13'h1;
        chk(program_counter, epc);
    endtask
    // file command: preload file f, run it, check file, accum and zero flag
    task automatic fop(input logic [2:0] op, input logic d, input logic [6:0] f,
                       input logic [7:0] fv, input logic [7:0] ef, input logic [7:0] ea,
                       input logic ez);
        bus(1'b1, cpuse_pkg::OFF_FADDR, {25'h0, f});
        bus(1'b1, cpuse_pkg::OFF_FDATA, {24'h0, fv});
        cmd(op, {3'h0, d, f});
        bus(1'b0, cpuse_pkg::OFF_FDATA, 32'h0);
        chk(rv, {24'h0, ef});
        bus(1'b0, cpuse_pkg::OFF_ACCUM, 32'h0);
        chk(rv, {24'h0, ea});
        bus(1'b0, cpuse_pkg::OFF_STAT, 32'h0);
        chk(rv[0], ez);
    endtask
    // verdict, reached from the tests or the watchdog
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        bus(1'b1, cpuse_pkg::OFF_PAGE, 32'h18);
        pg = 5'h18;
        cmd(cpuse_pkg::OP_CALL, 11'h2a5);
        bus(1'b0, cpuse_pkg::OFF_STAT, 32'h0);
        chk(rv[2:0], 3'h6);
        bus(1'b1, cpuse_pkg::OFF_PAGE, 32'h08);
        pg = 5'h08;
        cmd(cpuse_pkg::OP_CALL, 11'h7ff);
        fop(cpuse_pkg::OP_FINV, 1'b0, 7'h03, 8'h5a, 8'h5a, 8'ha5, 1'b0);
        fop(cpuse_pkg::OP_FZERO, 1'b0, 7'h03, 8'h77, 8'h00, 8'ha5, 1'b1);
        fop(cpuse_pkg::OP_FDEC, 1'b0, 7'h00, 8'h00, 8'h00, 8'hff, 1'b0);
        fop(cpuse_pkg::OP_AZERO, 1'b0, 7'h00, 8'h33, 8'h33, 8'h00, 1'b1);
        fop(cpuse_pkg::OP_FINV, 1'b1, 7'h40, 8'h0f, 8'hf0, 8'h00, 1'b0);
        fop(cpuse_pkg::OP_FINV, 1'b1, 7'h40, 8'hff, 8'h00, 8'h00, 1'b1);
        fop(cpuse_pkg::OP_FDEC, 1'b1, 7'h7f, 8'h00, 8'hff, 8'h00, 1'b0);
        fop(cpuse_pkg::OP_FDEC, 1'b1, 7'h7f, 8'h01, 8'h00, 8'h00, 1'b1);
        // unmapped offset: write dropped, read gives zero
        bus(1'b1, 8'h24, 32'hffff_ffff);
        bus(1'b0, 8'h24, 32'h0);
        chk(rv, 32'h0);
        // let the watchdog wrap once (256 x 256 clocks) so the kick has work to do
        repeat (66000) @(posedge clk_sys);
        chk(timeout_flag, 1'b0);
        cmd(cpuse_pkg::OP_KICK, 11'h0);
        chk(timeout_flag, 1'b1);
        chk(powerdown_flag, 1'b1);
        bus(1'b0, cpuse_pkg::OFF_WDOG, 32'h0);
        chk(rv[7:0], 8'h00);
        chk(rv[15:8] < 8'h08, 1'b1);
        close_out();
    end
    // hang guard: tests need about 66500 cycles
    initial begin
        #750000;
        n_mismatch++;
        close_out();
    end
endmodule
`default_nettype wire
